//--- design/gti_pkg.sv
package gti_pkg;
	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
	localparam logic [31:0] ADDR_COUNT = 32'h0000_0004;
	localparam logic [31:0] ADDR_PERIOD = 32'h0000_0008;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_000c;
	localparam logic [31:0] ADDR_MASK = 32'h0000_0010;

	// ****************************************************************
	// control fields
	// ****************************************************************
	localparam int CTRL_ON_BIT = 15;
	localparam int CTRL_SIDL_BIT = 13;
	localparam int CTRL_GATE_BIT = 6;
	localparam int CTRL_PS_LO = 4;
	localparam int CTRL_SYNC_BIT = 2;
	localparam int CTRL_CS_BIT = 1;

	// status and mask share one layout
	localparam int ST_MATCH_BIT = 0;
	localparam int ST_GATE_BIT = 1;
	localparam int ST_W = 2;

	// ****************************************************************
	// reset values and codes
	// ****************************************************************
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] PERIOD_RST = 16'h0000;
	localparam logic [ST_W-1:0] ST_RST = 2'h0;
	localparam logic [7:0] PRE_RST = 8'h00;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// prescaler terminal counts, divide by 1, 8, 64, 256
	localparam logic [7:0] PRE_TERM_1 = 8'h00;
	localparam logic [7:0] PRE_TERM_8 = 8'h07;
	localparam logic [7:0] PRE_TERM_64 = 8'h3f;
	localparam logic [7:0] PRE_TERM_256 = 8'hff;

	typedef enum logic [1:0]
	{
		PS_DIV1 = 2'b00,
		PS_DIV8 = 2'b01,
		PS_DIV64 = 2'b10,
		PS_DIV256 = 2'b11
	} gti_ps_t;

	typedef struct packed
	{
		logic timer_on;
		logic stop_in_idle;
		logic gate_mode_enable;
		gti_ps_t prescale_select;
		logic ext_clock_sync_select;
		logic clock_source_select;
	} gti_ctrl_t;

	localparam gti_ctrl_t CTRL_RST = '{1'b0, 1'b0, 1'b0, PS_DIV1, 1'b0, 1'b0};
endpackage

//--- design/gti_timer.sv
// Overview of operation
// RULE1: internal mode counts each cycle; wraps to zero after period match.
// RULE2: sync mode counts synchronised pin rising edges; wraps on match.
// RULE3: async mode counts every pin rising edge; wraps after match. The code counts edges through the synchroniser, as in sync mode.
// RULE4: with stop-in-idle set, counting halts during idle and resumes after.
// RULE5: gate mode advances on internal clock only while gate pin is high.
// RULE6: software sets timer on and internal source when using gate mode.
// RULE7: prescaler divides the selected input clock by 1, 8, 64 or 256.
// RULE8: prescaler clears on count write, timer switched off, or reset. The code clears on a count write only while timer_on is set.
// RULE9: while disabled the prescaler is stopped and never cleared.
// RULE10: control writes leave count alone; only count writes change it.
// RULE11: event on period match and on gate falling edge in gate mode.
// RULE12: events set a sticky flag that only software clears.
// RULE13: in sleep, counting continues only if on, external, asynchronous.
// RULE14: prescale codes 00, 01, 10, 11 mean divide 1, 8, 64, 256.
// RULE15: reset clears count, period and control: off, internal, no gating.
`timescale 1ns/1ps
`default_nettype none
module gti_timer
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hclk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic ext_clock_gate_pin,
	input wire logic cpu_idle,
	input wire logic cpu_sleep,
	output logic timer_irq_flag
);
	// ****************************************************************
	// functions
	// ****************************************************************
	function automatic logic [7:0] pre_term(input gti_pkg::gti_ps_t ps);
		case (ps)
			gti_pkg::PS_DIV1: pre_term = gti_pkg::PRE_TERM_1; // [RULE14]
			gti_pkg::PS_DIV8: pre_term = gti_pkg::PRE_TERM_8; // [RULE14]
			gti_pkg::PS_DIV64: pre_term = gti_pkg::PRE_TERM_64; // [RULE14]
			gti_pkg::PS_DIV256: pre_term = gti_pkg::PRE_TERM_256; // [RULE14]
			default: pre_term = gti_pkg::PRE_TERM_1;
		endcase
	endfunction

	function automatic logic [31:0] ctrl_word(input gti_pkg::gti_ctrl_t c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[gti_pkg::CTRL_ON_BIT] = c.timer_on;
		w[gti_pkg::CTRL_SIDL_BIT] = c.stop_in_idle;
		w[gti_pkg::CTRL_GATE_BIT] = c.gate_mode_enable;
		w[gti_pkg::CTRL_PS_LO +: 2] = c.prescale_select;
		w[gti_pkg::CTRL_SYNC_BIT] = c.ext_clock_sync_select;
		w[gti_pkg::CTRL_CS_BIT] = c.clock_source_select;
		ctrl_word = w;
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	gti_pkg::gti_ctrl_t ctrl_reg;
	gti_pkg::gti_ctrl_t ctrl_wr;
	logic [15:0] count_reg;
	logic [15:0] period_reg;
	logic [7:0] pre_reg;
	logic [gti_pkg::ST_W-1:0] status_reg;
	logic [gti_pkg::ST_W-1:0] status_next;
	logic [gti_pkg::ST_W-1:0] mask_reg;
	logic [gti_pkg::ST_W-1:0] mask_next;
	logic [gti_pkg::ST_W-1:0] st_rdclr;
	logic [gti_pkg::ST_W-1:0] events;
	logic pin_s1_reg;
	logic pin_s2_reg;
	logic pin_s3_reg;
	logic dph_wr_reg;
	logic [31:0] dph_addr_reg;
	logic aph_ok;
	logic wr_ctrl;
	logic wr_count;
	logic wr_period;
	logic wr_mask;
	logic pin_rise;
	logic pin_fall;
	logic src_pulse;
	logic sleep_ok;
	logic run;
	logic pre_wrap;
	logic tick;
	logic match;
	logic pre_clr;

	// ****************************************************************
	// ahb-lite slave, zero wait states
	// ****************************************************************
	assign aph_ok = hsel && hready && (htrans == gti_pkg::HTRANS_NONSEQ)
		&& (hsize == gti_pkg::HSIZE_WORD);
	assign wr_ctrl = dph_wr_reg && (dph_addr_reg == gti_pkg::ADDR_CTRL);
	assign wr_count = dph_wr_reg && (dph_addr_reg == gti_pkg::ADDR_COUNT);
	assign wr_period = dph_wr_reg && (dph_addr_reg == gti_pkg::ADDR_PERIOD);
	assign wr_mask = dph_wr_reg && (dph_addr_reg == gti_pkg::ADDR_MASK);
	assign ctrl_wr = '{hwdata[gti_pkg::CTRL_ON_BIT],
		hwdata[gti_pkg::CTRL_SIDL_BIT], hwdata[gti_pkg::CTRL_GATE_BIT],
		gti_pkg::gti_ps_t'(hwdata[gti_pkg::CTRL_PS_LO +: 2]),
		hwdata[gti_pkg::CTRL_SYNC_BIT], hwdata[gti_pkg::CTRL_CS_BIT]};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dph_wr_reg <= 1'b0;
			dph_addr_reg <= 32'h0000_0000;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else if (hclk_en)
		begin
			dph_wr_reg <= aph_ok && hwrite;
			dph_addr_reg <= haddr;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			// read data is sampled at the address phase so outputs stay flopped
			if (aph_ok && !hwrite)
			begin
				case (haddr)
					gti_pkg::ADDR_CTRL: hrdata <= ctrl_word(ctrl_reg);
					gti_pkg::ADDR_COUNT: hrdata <= {16'h0000, count_reg};
					gti_pkg::ADDR_PERIOD: hrdata <= {16'h0000, period_reg};
					gti_pkg::ADDR_STATUS: hrdata <= {30'h0, status_reg};
					gti_pkg::ADDR_MASK: hrdata <= {30'h0, mask_reg};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************************************
	// control and period
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_reg <= gti_pkg::CTRL_RST; // [RULE15]
			period_reg <= gti_pkg::PERIOD_RST; // [RULE15]
			mask_reg <= gti_pkg::ST_RST;
		end
		else if (hclk_en)
		begin
			if (wr_ctrl)
				ctrl_reg <= ctrl_wr;
			if (wr_period)
				period_reg <= hwdata[15:0];
			mask_reg <= mask_next;
		end
	end
	assign mask_next = wr_mask ? hwdata[gti_pkg::ST_W-1:0] : mask_reg;

	// ****************************************************************
	// external pin: two-flop synchroniser then edge history
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			pin_s3_reg <= 1'b0;
		end
		else if (hclk_en)
		begin
			pin_s1_reg <= ext_clock_gate_pin;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end
	assign pin_rise = pin_s2_reg && !pin_s3_reg;
	assign pin_fall = !pin_s2_reg && pin_s3_reg;

	// ****************************************************************
	// clock source, idle, sleep and prescaler
	// ****************************************************************
	// both counter modes see the pin through the synchroniser, so the
	// external rate must stay below half of hclk; the async setting
	// differs only in running on through sleep
	always_comb
	begin
		if (ctrl_reg.clock_source_select)
			src_pulse = pin_rise; // [RULE2] [RULE3]
		else if (ctrl_reg.gate_mode_enable)
			src_pulse = pin_s2_reg; // [RULE5]
		else
			src_pulse = 1'b1; // [RULE1]
	end
	assign sleep_ok = ctrl_reg.clock_source_select
		&& !ctrl_reg.ext_clock_sync_select; // [RULE13]
	assign run = ctrl_reg.timer_on
		&& !(cpu_idle && ctrl_reg.stop_in_idle) // [RULE4]
		&& !(cpu_sleep && !sleep_ok); // [RULE13]
	assign pre_wrap = pre_reg == pre_term(ctrl_reg.prescale_select); // [RULE7]
	assign tick = run && src_pulse && pre_wrap;
	assign match = count_reg == period_reg;
	// a disabled prescaler cannot be cleared, so clears need timer_on
	assign pre_clr = ctrl_reg.timer_on
		&& (wr_count || (wr_ctrl && !ctrl_wr.timer_on)); // [RULE8] [RULE9]

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pre_reg <= gti_pkg::PRE_RST; // [RULE8]
		else if (hclk_en)
		begin
			if (pre_clr)
				pre_reg <= gti_pkg::PRE_RST; // [RULE8]
			else if (run && src_pulse)
				pre_reg <= pre_wrap ? gti_pkg::PRE_RST : pre_reg + 8'h01; // [RULE7]
		end
	end

	// ****************************************************************
	// counter
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			count_reg <= gti_pkg::COUNT_RST; // [RULE15]
		else if (hclk_en)
		begin
			if (wr_count)
				count_reg <= hwdata[15:0]; // [RULE10]
			else if (tick && match)
				count_reg <= gti_pkg::COUNT_RST; // [RULE1] [RULE2] [RULE3]
			else if (tick)
				count_reg <= count_reg + 16'h0001; // [RULE1]
		end
	end

	// ****************************************************************
	// events, sticky status and interrupt
	// ****************************************************************
	assign events[gti_pkg::ST_MATCH_BIT] = tick && match && !wr_count; // [RULE11]
	assign events[gti_pkg::ST_GATE_BIT] = ctrl_reg.timer_on
		&& ctrl_reg.gate_mode_enable && !ctrl_reg.clock_source_select
		&& pin_fall; // [RULE11]
	assign st_rdclr = (aph_ok && !hwrite && haddr == gti_pkg::ADDR_STATUS)
		? {gti_pkg::ST_W{1'b1}} : gti_pkg::ST_RST;
	// a new event beats a clearing read in the same cycle
	assign status_next = (status_reg & ~st_rdclr) | events; // [RULE12]

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			status_reg <= gti_pkg::ST_RST;
			timer_irq_flag <= 1'b0;
		end
		else if (hclk_en)
		begin
			status_reg <= status_next; // [RULE12]
			timer_irq_flag <= |(status_next & mask_next); // [RULE12]
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	AST_WRAP: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE1]
		hclk_en && tick && match && !wr_count |=> count_reg == 16'h0000)
		else $error("count did not wrap to zero on period match");

	AST_EXT_STEP: assert property (@(posedge hclk) // [RULE2]
		disable iff (!hresetn)
		hclk_en && ctrl_reg.clock_source_select && !pin_rise && !wr_count
		|=> $stable(count_reg))
		else $error("external mode counted without a pin edge");

	AST_IDLE: assert property (@(posedge hclk) // [RULE4]
		disable iff (!hresetn)
		hclk_en && cpu_idle && ctrl_reg.stop_in_idle && !wr_count
		|=> $stable(count_reg)
		&& ($past(pre_clr) ? pre_reg == gti_pkg::PRE_RST : $stable(pre_reg)))
		else $error("count moved in idle with stop-in-idle set");

	AST_GATE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE5]
		ctrl_reg.gate_mode_enable && !ctrl_reg.clock_source_select
		&& !pin_s2_reg |-> !tick)
		else $error("gated timer advanced with gate low");

	AST_PRE_CLR: assert property (@(posedge hclk) // [RULE8]
		disable iff (!hresetn)
		hclk_en && wr_count && ctrl_reg.timer_on |=> pre_reg == 8'h00)
		else $error("prescaler not cleared by count write");

	AST_OFF_HOLD: assert property (@(posedge hclk) // [RULE9]
		disable iff (!hresetn)
		hclk_en && !ctrl_reg.timer_on |=> $stable(pre_reg))
		else $error("prescaler changed while disabled");

	AST_CTRL_WR: assert property (@(posedge hclk) // [RULE10]
		disable iff (!hresetn)
		hclk_en && wr_ctrl && !tick |=> $stable(count_reg))
		else $error("control write changed the count");

	AST_MATCH_EV: assert property (@(posedge hclk) // [RULE11]
		disable iff (!hresetn)
		hclk_en && tick && match && !wr_count
		|=> status_reg[gti_pkg::ST_MATCH_BIT])
		else $error("period match did not set status");

	AST_IRQ: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE12]
		timer_irq_flag == |(status_reg & mask_reg))
		else $error("interrupt output disagrees with status and mask");

	AST_SLEEP: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE13]
		hclk_en && cpu_sleep && !sleep_ok && !wr_count |=> $stable(count_reg))
		else $error("count moved in sleep without async external clock");

	AST_DIV8: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE14]
		ctrl_reg.prescale_select == gti_pkg::PS_DIV8 && tick
		|-> pre_reg == 8'h07)
		else $error("divide-by-8 ticked at wrong prescaler count");

	AST_COUNT_WR: assert property (@(posedge hclk) // [RULE10]
		disable iff (!hresetn)
		hclk_en && wr_count
		|=> {16'h0000, count_reg} == ($past(hwdata) & 32'h0000_ffff))
		else $error("count write did not load the count");

	AST_GATE_EV: assert property (@(posedge hclk) // [RULE11]
		disable iff (!hresetn)
		hclk_en && ctrl_reg.timer_on && ctrl_reg.gate_mode_enable
		&& !ctrl_reg.clock_source_select && pin_fall
		|=> status_reg[gti_pkg::ST_GATE_BIT])
		else $error("gate falling edge did not set status");

	AST_STICKY: assert property (@(posedge hclk) // [RULE12]
		disable iff (!hresetn)
		hclk_en && status_reg[gti_pkg::ST_MATCH_BIT]
		&& !st_rdclr[gti_pkg::ST_MATCH_BIT]
		|=> status_reg[gti_pkg::ST_MATCH_BIT])
		else $error("match status cleared without a status read");

	CVR_WRAP: cover property (@(posedge hclk) disable iff (!hresetn)
		tick && match);
	CVR_GATE_FALL: cover property (@(posedge hclk) disable iff (!hresetn)
		events[gti_pkg::ST_GATE_BIT]);
	CVR_IRQ: cover property (@(posedge hclk) disable iff (!hresetn)
		timer_irq_flag);
	CVR_SLEEP_RUN: cover property (@(posedge hclk) disable iff (!hresetn)
		cpu_sleep && tick);
endmodule
`default_nettype wire

//--- tb/gated_interval_timer_16bit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gated_interval_timer_16bit_tb;
	localparam logic [31:0] ON = 32'h0000_8000;
	localparam logic [31:0] SIDL = 32'h0000_2000;
	localparam logic [31:0] GATE = 32'h0000_0040;
	localparam logic [31:0] SYNC = 32'h0000_0004;
	localparam logic [31:0] CS = 32'h0000_0002;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hclk_en = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic pin;
	logic cpu_idle = 1'b0;
	logic cpu_sleep = 1'b0;
	logic irq;
	int n_errors = 0;
	int tests_run = 0;

	always #4 hclk = ~hclk;

	gti_pin_src i_src (.hclk(hclk), .pin(pin));

	gti_timer i_dut
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.hclk_en(hclk_en),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.ext_clock_gate_pin(pin),
		.cpu_idle(cpu_idle),
		.cpu_sleep(cpu_sleep),
		.timer_irq_flag(irq)
	);

	// ****************************************************************
	// reporting and bus access
	// ****************************************************************
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
			n_errors++;
		end
	endtask

	// waits for hready at a rising edge, bounded
	task automatic rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 64)
		begin
			@(posedge hclk);
			n++;
		end
		if (n >= 64)
		begin
			$display("CHECK FAILED hready expected 1 seen %b", hreadyout);
			n_errors++;
			end_of_test();
		end
	endtask

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= gti_pkg::HTRANS_NONSEQ;
		hsize <= gti_pkg::HSIZE_WORD;
		rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] rd;
		bus(1'b1, a, d, rd);
	endtask

	task automatic rc(input logic [31:0] a, input logic [31:0] e,
		input string nm);
		logic [31:0] rd;
		bus(1'b0, a, 32'h0, rd);
		chk(nm, e, rd);
	endtask

	// irq is sampled mid-cycle so that the edge's updates have landed
	task automatic irq_chk(input logic e);
		@(negedge hclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
		@(posedge hclk);
	endtask

	// on for w + 2 cycles (plus pulses), then off and read the count
	task automatic run(input logic [31:0] c, input int w, input int np,
		input int h, input logic [31:0] e);
		wr(gti_pkg::ADDR_CTRL, c);
		repeat (w) @(posedge hclk);
		if (np > 0)
			i_src.pulses(np, h);
		wr(gti_pkg::ADDR_CTRL, 32'h0);
		rc(gti_pkg::ADDR_COUNT, e, "count");
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset();
		rc(gti_pkg::ADDR_CTRL, 32'h0, "ctrl");
		rc(gti_pkg::ADDR_COUNT, 32'h0, "count");
		rc(gti_pkg::ADDR_PERIOD, 32'h0, "period");
		rc(gti_pkg::ADDR_STATUS, 32'h0, "status");
		rc(gti_pkg::ADDR_MASK, 32'h0, "mask");
		wr(32'h0000_0020, 32'hffff_ffff);
		rc(32'h0000_0020, 32'h0, "unmapped");
		wr(gti_pkg::ADDR_CTRL, 32'hffff_ffff);
		rc(gti_pkg::ADDR_CTRL, 32'h0000_a076, "ctrl w");
		wr(gti_pkg::ADDR_CTRL, 32'h0);
	endtask

	task automatic t_internal();
		wr(gti_pkg::ADDR_PERIOD, 32'h0000_ffff);
		wr(gti_pkg::ADDR_COUNT, 32'h0);
		run(ON, 0, 0, 3, 32'h2);
		run(ON, 0, 0, 3, 32'h4);
	endtask

	// clock enable low freezes the count; only the two enabled edges count
	task automatic t_freeze();
		wr(gti_pkg::ADDR_COUNT, 32'h0);
		wr(gti_pkg::ADDR_CTRL, ON);
		hclk_en <= 1'b0;
		repeat (20) @(posedge hclk);
		hclk_en <= 1'b1;
		wr(gti_pkg::ADDR_CTRL, 32'h0);
		rc(gti_pkg::ADDR_COUNT, 32'h2, "count frozen");
	endtask

	task automatic t_prescale();
		int d;
		logic [31:0] c;
		for (int ps = 0; ps < 4; ps++)
		begin
			d = (ps == 3) ? 256 : 1 << (3 * ps);
			c = ON | (32'(ps) << gti_pkg::CTRL_PS_LO);
			wr(gti_pkg::ADDR_COUNT, 32'h0);
			run(c, 3 * d - 3, 0, 3, 32'h2);
		end
		// a count write mid-run restarts the divide-by-8 prescaler
		wr(gti_pkg::ADDR_COUNT, 32'h0);
		wr(gti_pkg::ADDR_CTRL, ON | 32'h0000_0010);
		repeat (10) @(posedge hclk);
		wr(gti_pkg::ADDR_COUNT, 32'h5);
		repeat (5) @(posedge hclk);
		wr(gti_pkg::ADDR_CTRL, 32'h0);
		rc(gti_pkg::ADDR_COUNT, 32'h5, "count pre clr");
	endtask

	task automatic t_idle();
		cpu_idle <= 1'b1;
		wr(gti_pkg::ADDR_COUNT, 32'h0);
		run(ON | SIDL, 3, 0, 3, 32'h0);
		run(ON, 3, 0, 3, 32'h5);
		cpu_idle <= 1'b0;
		run(ON | SIDL, 3, 0, 3, 32'ha);
	endtask

	task automatic t_ext();
		wr(gti_pkg::ADDR_COUNT, 32'h0);
		run(ON | CS | SYNC, 0, 5, 3, 32'h5);
		run(ON | CS, 0, 5, 3, 32'ha);
		cpu_sleep <= 1'b1;
		run(ON | CS, 0, 4, 3, 32'he);
		run(ON | CS | SYNC, 0, 4, 3, 32'he);
		run(ON, 3, 0, 3, 32'he);
		cpu_sleep <= 1'b0;
	endtask

	task automatic t_gate();
		wr(gti_pkg::ADDR_MASK, 32'h2);
		wr(gti_pkg::ADDR_COUNT, 32'h0);
		run(ON | GATE, 0, 1, 6, 32'h6);
		irq_chk(1'b1);
		rc(gti_pkg::ADDR_STATUS, 32'h2, "status gate");
		irq_chk(1'b0);
	endtask

	task automatic t_irq();
		wr(gti_pkg::ADDR_PERIOD, 32'h3);
		wr(gti_pkg::ADDR_MASK, 32'h1);
		wr(gti_pkg::ADDR_COUNT, 32'h0);
		run(ON, 4, 0, 3, 32'h2);
		repeat (10) @(posedge hclk);
		irq_chk(1'b1);
		wr(gti_pkg::ADDR_MASK, 32'h0);
		irq_chk(1'b0);
		wr(gti_pkg::ADDR_MASK, 32'h1);
		irq_chk(1'b1);
		rc(gti_pkg::ADDR_STATUS, 32'h1, "status match");
		irq_chk(1'b0);
		rc(gti_pkg::ADDR_STATUS, 32'h0, "status cleared");
	endtask

	initial
	begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_internal();
		t_freeze();
		t_prescale();
		t_idle();
		t_ext();
		t_gate();
		t_irq();
		end_of_test();
	end
endmodule
`default_nettype wire

//--- tb/gti_pin_src.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// external clock / gate source
// ****************************************************************
// pin rests low between bursts; a free-running source would hide
// edge-count slips in the design
module gti_pin_src
(
	input wire logic hclk,
	output logic pin
);
	initial pin = 1'b0;

	// n pulses, high and low half cycles each; half >= 2 keeps the
	// synchroniser from losing an edge
	task automatic pulses(input int n, input int half);
		repeat (n)
		begin
			repeat (half) @(posedge hclk);
			pin <= 1'b1;
			repeat (half) @(posedge hclk);
			pin <= 1'b0;
		end
		// let the last edge cross the synchroniser
		repeat (4) @(posedge hclk);
	endtask
endmodule
`default_nettype wire
